// >>> logic/actr_cfg.svh
// Register offsets, field layouts and reset values of the core trim register bank.
`ifndef ACTR_CFG_SVH
`define ACTR_CFG_SVH

`define ACTR_ADDR_W          10
`define ACTR_DATA_W          16
`define ACTR_OFS_W           12
`define ACTR_GAIN_W          5
`define ACTR_OFS_REG_W       16
`define ACTR_GAIN_REG_W      8

`define ACTR_OFF_C3_OFS_C    10'h338
`define ACTR_OFF_C3_OFS_D    10'h33a
`define ACTR_OFF_C4_OFS      10'h33c
`define ACTR_OFF_C5_OFS      10'h33e
`define ACTR_OFF_C0_GAIN     10'h360
`define ACTR_OFF_C1_GAIN     10'h361
`define ACTR_OFF_C2_GAIN_A   10'h362
`define ACTR_OFF_C2_GAIN_B   10'h363

`define ACTR_OFS_RST         16'h0000
`define ACTR_GAIN_RST        8'h00

`endif

// >>> logic/actr_pkg.sv
// Types shared by the core trim register bank.
package actr_pkg;

  typedef enum logic [1:0] {
    ACTR_ST_LOAD = 2'h1,
    ACTR_ST_RUN  = 2'h2
  } actr_state_e;

endpackage

// >>> logic/actr_trim_regs.sv
// Core trim register bank: offset trims for cores 3 to 5, fine gain trims for cores 0 to 2.
//
// Operation
// RULE_01: Core 3 on input pair C gets offset trim bits 11:0 at 0x338.
// RULE_02: Core 3 on input pair D gets offset trim bits 11:0 at 0x33A.
// RULE_03: Core 4 always gets offset trim bits 11:0 at 0x33C.
// RULE_04: Core 5 always gets offset trim bits 11:0 at 0x33E.
// RULE_05: Core 0 gain scaled by fine gain trim bits 4:0 at 0x360.
// RULE_06: Core 1 gain scaled by fine gain trim bits 4:0 at 0x361.
// RULE_07: Core 2 on input pair A uses gain trim bits 4:0 at 0x362.
// RULE_08: Core 2 on input pair B uses gain trim bits 4:0 at 0x363.
// RULE_09: Offset trim defaults come from fuse storage when defaults are restored.
// RULE_10: Fine gain trim defaults come from fuse storage when defaults are restored.
// RULE_11: Offset trim fields are unsigned quantities added to conversion results.
// RULE_12: Software must not touch offset trims during offset calibration.
// RULE_13: Foreground-only calibration: wait for calibration complete before offset access.
// RULE_14: Software writes zero into reserved upper bits of every trim register.
`include "actr_cfg.svh"

module actr_trim_regs
  import actr_pkg::*;
#(
  parameter int ADDR_W = `ACTR_ADDR_W,
  parameter int DATA_W = `ACTR_DATA_W
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic [ADDR_W-1:0]        reg_addr,
  input  wire logic [DATA_W-1:0]        reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output logic      [DATA_W-1:0]        reg_rdata,
  input  wire logic                     restore_defaults,
  input  wire logic [4*`ACTR_OFS_REG_W-1:0] fuse_offset,
  input  wire logic [4*`ACTR_GAIN_REG_W-1:0] fuse_gain,
  input  wire logic                     core3_on_pair_d,
  input  wire logic                     core2_on_pair_b,
  output logic      [`ACTR_OFS_W-1:0]   core3_offset,
  output logic      [`ACTR_OFS_W-1:0]   core4_offset,
  output logic      [`ACTR_OFS_W-1:0]   core5_offset,
  output logic      [`ACTR_GAIN_W-1:0]  core0_gain,
  output logic      [`ACTR_GAIN_W-1:0]  core1_gain,
  output logic      [`ACTR_GAIN_W-1:0]  core2_gain,
  output logic                          defaults_loading
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Fuse default loading
  // ----------------------------------------------------------------------
  // The fuse image is a port value, so it cannot be the async reset value;
  // it is copied by a clocked load in the first cycle after reset release.
  actr_state_e state;
  logic        load;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ACTR_ST_LOAD;
    end else begin
      case (state)
        ACTR_ST_LOAD: state <= ACTR_ST_RUN;
        ACTR_ST_RUN:  state <= restore_defaults ? ACTR_ST_LOAD : ACTR_ST_RUN;
        default:      state <= ACTR_ST_LOAD;
      endcase
    end
  end

  assign load             = (state == ACTR_ST_LOAD);
  assign defaults_loading = load;

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [`ACTR_OFS_REG_W-1:0]  ofs_reg  [4];
  logic [`ACTR_GAIN_REG_W-1:0] gain_reg [4];
  logic [ADDR_W-1:0]           ofs_addr [4];
  logic [ADDR_W-1:0]           gain_addr[4];

  assign ofs_addr[0]  = `ACTR_OFF_C3_OFS_C;
  assign ofs_addr[1]  = `ACTR_OFF_C3_OFS_D;
  assign ofs_addr[2]  = `ACTR_OFF_C4_OFS;
  assign ofs_addr[3]  = `ACTR_OFF_C5_OFS;
  assign gain_addr[0] = `ACTR_OFF_C0_GAIN;
  assign gain_addr[1] = `ACTR_OFF_C1_GAIN;
  assign gain_addr[2] = `ACTR_OFF_C2_GAIN_A;
  assign gain_addr[3] = `ACTR_OFF_C2_GAIN_B;

  // Reserved upper bits are stored as written and read back, since they
  // are plain read/write; software is expected to keep them zero. RULE_14
  for (genvar i = 0; i < 4; i++) begin : g_regs
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        ofs_reg[i] <= `ACTR_OFS_RST;
      end else if (load) begin
        ofs_reg[i] <= fuse_offset[i*`ACTR_OFS_REG_W +: `ACTR_OFS_REG_W]; // RULE_09
      end else if (reg_write && reg_addr == ofs_addr[i]) begin
        ofs_reg[i] <= reg_wdata[`ACTR_OFS_REG_W-1:0];
      end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        gain_reg[i] <= `ACTR_GAIN_RST;
      end else if (load) begin
        gain_reg[i] <= fuse_gain[i*`ACTR_GAIN_REG_W +: `ACTR_GAIN_REG_W]; // RULE_10
      end else if (reg_write && reg_addr == gain_addr[i]) begin
        gain_reg[i] <= reg_wdata[`ACTR_GAIN_REG_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    for (int j = 0; j < 4; j++) begin
      if (reg_addr == ofs_addr[j]) begin
        next_rdata = DATA_W'(ofs_reg[j]);
      end
      if (reg_addr == gain_addr[j]) begin
        next_rdata = DATA_W'(gain_reg[j]);
      end
    end
  end

  // Read data stands for the one cycle after the strobe and is zero otherwise.
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_read ? next_rdata : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Trim values to the converter cores
  // ----------------------------------------------------------------------
  // Fields are handed over as unsigned magnitudes, with no sign extension. RULE_11
  // Offset access during calibration is the controller's concern. RULE_12 RULE_13
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core3_offset <= '0;
      core4_offset <= '0;
      core5_offset <= '0;
    end else begin
      core3_offset <= core3_on_pair_d ? ofs_reg[1][`ACTR_OFS_W-1:0]  // RULE_02
                                      : ofs_reg[0][`ACTR_OFS_W-1:0]; // RULE_01
      core4_offset <= ofs_reg[2][`ACTR_OFS_W-1:0]; // RULE_03
      core5_offset <= ofs_reg[3][`ACTR_OFS_W-1:0]; // RULE_04
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core0_gain <= '0;
      core1_gain <= '0;
      core2_gain <= '0;
    end else begin
      core0_gain <= gain_reg[0][`ACTR_GAIN_W-1:0]; // RULE_05
      core1_gain <= gain_reg[1][`ACTR_GAIN_W-1:0]; // RULE_06
      core2_gain <= core2_on_pair_b ? gain_reg[3][`ACTR_GAIN_W-1:0]  // RULE_08
                                    : gain_reg[2][`ACTR_GAIN_W-1:0]; // RULE_07
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_wr_c3c;
    reg_write && reg_addr == `ACTR_OFF_C3_OFS_C && !load;
  endsequence

  sequence s_wr_g2b;
    reg_write && reg_addr == `ACTR_OFF_C2_GAIN_B && !load;
  endsequence

  sequence s_wr_c3d;
    reg_write && reg_addr == `ACTR_OFF_C3_OFS_D && !load;
  endsequence

  sequence s_wr_c5;
    reg_write && reg_addr == `ACTR_OFF_C5_OFS && !load;
  endsequence

  sequence s_wr_g0;
    reg_write && reg_addr == `ACTR_OFF_C0_GAIN && !load;
  endsequence

  sequence s_wr_g1;
    reg_write && reg_addr == `ACTR_OFF_C1_GAIN && !load;
  endsequence

  sequence s_wr_g2a;
    reg_write && reg_addr == `ACTR_OFF_C2_GAIN_A && !load;
  endsequence

  sequence s_rd_c4;
    reg_read && reg_addr == `ACTR_OFF_C4_OFS;
  endsequence

  sequence s_rd_g1;
    reg_read && reg_addr == `ACTR_OFF_C1_GAIN;
  endsequence

  AST_C3_PAIR_C: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_01
    !core3_on_pair_d |=> core3_offset == $past(ofs_reg[0][`ACTR_OFS_W-1:0]))
    else $error("core 3 offset does not follow pair C trim");

  AST_C3_PAIR_D: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_02
    core3_on_pair_d |=> core3_offset == $past(ofs_reg[1][`ACTR_OFS_W-1:0]))
    else $error("core 3 offset does not follow pair D trim");

  AST_C4_OFS: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_03
    reg_write && reg_addr == `ACTR_OFF_C4_OFS && !load && !restore_defaults
    |=> ##1 core4_offset == $past(reg_wdata[`ACTR_OFS_W-1:0], 2))
    else $error("core 4 offset does not reach output two cycles after write");

  AST_C5_OFS: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_04
    ##1 core5_offset == $past(ofs_reg[3][`ACTR_OFS_W-1:0]))
    else $error("core 5 offset mismatch");

  AST_C0_GAIN: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_05
    ##1 core0_gain == $past(gain_reg[0][`ACTR_GAIN_W-1:0]))
    else $error("core 0 gain mismatch");

  AST_C1_GAIN: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_06
    ##1 core1_gain == $past(gain_reg[1][`ACTR_GAIN_W-1:0]))
    else $error("core 1 gain mismatch");

  AST_C2_PAIR_A: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_07
    !core2_on_pair_b |=> core2_gain == $past(gain_reg[2][`ACTR_GAIN_W-1:0]))
    else $error("core 2 gain does not follow pair A trim");

  AST_C2_PAIR_B: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_08
    s_wr_g2b ##1 (core2_on_pair_b && !load)
    |=> core2_gain == $past(reg_wdata[`ACTR_GAIN_W-1:0], 2))
    else $error("core 2 gain does not follow pair B write");

  AST_OFS_FUSE: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_09
    load |=> ofs_reg[2] == $past(fuse_offset[2*`ACTR_OFS_REG_W +: `ACTR_OFS_REG_W]))
    else $error("offset trim not loaded from fuse image");

  AST_GAIN_FUSE: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_10
    load |=> gain_reg[1] == $past(fuse_gain[`ACTR_GAIN_REG_W +: `ACTR_GAIN_REG_W]))
    else $error("gain trim not loaded from fuse image");

  AST_RESTORE: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_09
    restore_defaults && !load |=> load ##1 !load)
    else $error("restore did not give a single load cycle");

  AST_C3C_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_01
    s_wr_c3c ##1 (!core3_on_pair_d && !load)
    |=> core3_offset == $past(reg_wdata[`ACTR_OFS_W-1:0], 2))
    else $error("core 3 offset does not follow pair C write");

  AST_C3D_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_02
    s_wr_c3d ##1 (core3_on_pair_d && !load)
    |=> core3_offset == $past(reg_wdata[`ACTR_OFS_W-1:0], 2))
    else $error("core 3 offset does not follow pair D write");

  AST_C5_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_04
    s_wr_c5 |=> ##1 core5_offset == $past(reg_wdata[`ACTR_OFS_W-1:0], 2))
    else $error("core 5 offset does not reach output two cycles after write");

  AST_G0_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_05
    s_wr_g0 |=> ##1 core0_gain == $past(reg_wdata[`ACTR_GAIN_W-1:0], 2))
    else $error("core 0 gain does not reach output two cycles after write");

  AST_G1_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_06
    s_wr_g1 |=> ##1 core1_gain == $past(reg_wdata[`ACTR_GAIN_W-1:0], 2))
    else $error("core 1 gain does not reach output two cycles after write");

  AST_G2A_WRITE: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_07
    s_wr_g2a ##1 (!core2_on_pair_b && !load)
    |=> core2_gain == $past(reg_wdata[`ACTR_GAIN_W-1:0], 2))
    else $error("core 2 gain does not follow pair A write");

  AST_RD_C4: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_03
    s_rd_c4 |=> reg_rdata[`ACTR_OFS_REG_W-1:0] == $past(ofs_reg[2]))
    else $error("core 4 offset register does not read back");

  AST_RD_G1: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_06
    s_rd_g1 |=> reg_rdata[`ACTR_GAIN_REG_W-1:0] == $past(gain_reg[1]))
    else $error("core 1 gain register does not read back");

  AST_OFS_FUSE_C3C: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_09
    load |=> ofs_reg[0] == $past(fuse_offset[`ACTR_OFS_REG_W-1:0]))
    else $error("pair C offset trim not loaded from fuse image");

  AST_GAIN_FUSE_G2B: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE_10
    load |=> gain_reg[3] == $past(fuse_gain[4*`ACTR_GAIN_REG_W-1 -: `ACTR_GAIN_REG_W]))
    else $error("pair B gain trim not loaded from fuse image");

endmodule

// >>> bench/tb_actr_trim_regs.sv
// Self-checking testbench of the core trim register bank.
`include "actr_cfg.svh"

module tb_actr_trim_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  localparam logic [63:0] FUSE_OFS  = 64'h0d5c_0b2a_0e19_0f08;
  localparam logic [31:0] FUSE_GAIN = 32'h1e0d_17a3;

  logic        clock;
  logic        rst_n;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [15:0] reg_rdata;
  logic        restore_defaults;
  logic        core3_on_pair_d;
  logic        core2_on_pair_b;
  logic [11:0] core3_offset;
  logic [11:0] core4_offset;
  logic [11:0] core5_offset;
  logic [4:0]  core0_gain;
  logic [4:0]  core1_gain;
  logic [4:0]  core2_gain;
  logic        defaults_loading;
  int          errors;
  int          total_checks;
  logic [9:0]  addr_tab [8] = '{`ACTR_OFF_C3_OFS_C, `ACTR_OFF_C3_OFS_D, `ACTR_OFF_C4_OFS,
                                `ACTR_OFF_C5_OFS, `ACTR_OFF_C0_GAIN, `ACTR_OFF_C1_GAIN,
                                `ACTR_OFF_C2_GAIN_A, `ACTR_OFF_C2_GAIN_B};
  logic [15:0] exp_tab  [8];

  actr_trim_regs i_actr_trim_regs (
    .clock            (clock),
    .rst_n            (rst_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_write        (reg_write),
    .reg_read         (reg_read),
    .reg_rdata        (reg_rdata),
    .restore_defaults (restore_defaults),
    .fuse_offset      (FUSE_OFS),
    .fuse_gain        (FUSE_GAIN),
    .core3_on_pair_d  (core3_on_pair_d),
    .core2_on_pair_b  (core2_on_pair_b),
    .core3_offset     (core3_offset),
    .core4_offset     (core4_offset),
    .core5_offset     (core5_offset),
    .core0_gain       (core0_gain),
    .core1_gain       (core1_gain),
    .core2_gain       (core2_gain),
    .defaults_loading (defaults_loading)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data must stand in the cycle after the strobe only, then return to zero.
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, e);
    @(negedge clock);
    chk(reg_rdata, 16'h0000);
  endtask

  task automatic read_all();
    for (int i = 0; i < 8; i++) begin
      rd(addr_tab[i], exp_tab[i]);
    end
  endtask

  task automatic load_fuse_exp();
    for (int i = 0; i < 8; i++) begin
      exp_tab[i] = (i < 4) ? FUSE_OFS[16*i +: 16] : {8'h00, FUSE_GAIN[8*(i-4) +: 8]};
    end
  endtask

  // Both input pairs are visited, so a swapped select shows up as a mismatch.
  task automatic check_cores();
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      core3_on_pair_d <= s[0];
      core2_on_pair_b <= s[0];
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk({4'h0, core3_offset}, {4'h0, exp_tab[s][11:0]});
      chk({4'h0, core4_offset}, {4'h0, exp_tab[2][11:0]});
      chk({4'h0, core5_offset}, {4'h0, exp_tab[3][11:0]});
      chk({11'h0, core0_gain}, {11'h0, exp_tab[4][4:0]});
      chk({11'h0, core1_gain}, {11'h0, exp_tab[5][4:0]});
      chk({11'h0, core2_gain}, {11'h0, exp_tab[6+s][4:0]});
    end
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    repeat (4000) @(posedge clock);
    errors++;
    end_of_test();
  end

  initial begin
    errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    reg_addr = 10'h000;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    restore_defaults = 1'b0;
    core3_on_pair_d = 1'b0;
    core2_on_pair_b = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    load_fuse_exp();
    read_all();
    check_cores();
    // No calibration engine runs here, so every trim access is legal.
    for (int i = 0; i < 8; i++) begin
      exp_tab[i] = (16'h0a5c + 16'(i) * 16'h0713) & ((i < 4) ? 16'h0fff : 16'h001f);
      @(posedge clock);
      core3_on_pair_d <= i[0];
      core2_on_pair_b <= i[0];
      wr(addr_tab[i], exp_tab[i]);
    end
    wr(10'h340, 16'h0123);
    rd(10'h340, 16'h0000);
    read_all();
    check_cores();
    @(posedge clock);
    restore_defaults <= 1'b1;
    @(posedge clock);
    restore_defaults <= 1'b0;
    @(negedge clock);
    chk({15'h0, defaults_loading}, 16'h0001);
    @(negedge clock);
    chk({15'h0, defaults_loading}, 16'h0000);
    repeat (2) @(posedge clock);
    for (int n = 0; n < 20 && defaults_loading !== 1'b0; n++) @(posedge clock);
    load_fuse_exp();
    read_all();
    check_cores();
    end_of_test();
  end
endmodule
